//--- inc/etm_pkg.sv
// constants for the three-channel 8-bit timer block
// assumes an 8-bit register port with a 16-bit byte address
package etm_pkg;

  localparam int ETM_CH_N = 3;
  localparam int ETM_ADDR_W = 16;
  localparam int ETM_DATA_W = 8;
  localparam int ETM_PRE_W = 11;

  // mode control registers, one per channel
  localparam logic [15:0] ETM_MODE0_OFS = 16'hff79;
  localparam logic [15:0] ETM_MODE1_OFS = 16'hff7b;
  localparam logic [15:0] ETM_MODE2_OFS = 16'hff7d;
  // count clock select registers
  localparam logic [15:0] ETM_CSEL0_OFS = 16'hff78;
  localparam logic [15:0] ETM_CSEL1_OFS = 16'hff7a;
  localparam logic [15:0] ETM_CSEL2_OFS = 16'hff7c;
  // compare values and read-only counts
  localparam logic [15:0] ETM_CMP0_OFS = 16'hff60;
  localparam logic [15:0] ETM_CMP1_OFS = 16'hff61;
  localparam logic [15:0] ETM_CMP2_OFS = 16'hff62;
  localparam logic [15:0] ETM_CNT0_OFS = 16'hff64;
  localparam logic [15:0] ETM_CNT1_OFS = 16'hff65;
  localparam logic [15:0] ETM_CNT2_OFS = 16'hff66;

  // mode control field positions
  localparam int ETM_RUN_BIT = 7;
  localparam int ETM_PWM_BIT = 6;
  localparam int ETM_CHAIN_BIT = 4;
  localparam int ETM_SET_BIT = 3;
  localparam int ETM_CLR_BIT = 2;
  localparam int ETM_TGL_BIT = 1;
  localparam int ETM_DRV_BIT = 0;

  // stored bits: bit 5 reads zero, bits 3:2 are one-shot commands
  localparam logic [7:0] ETM_MODE_WMASK = 8'hd3;
  localparam logic [7:0] ETM_MODE_RST = 8'h04;
  localparam logic [7:0] ETM_CMP_RST = 8'h00;
  localparam logic [2:0] ETM_CSEL_RST = 3'h0;
  localparam logic [7:0] ETM_CNT_RST = 8'h00;
  localparam logic [7:0] ETM_CNT_TOP = 8'hff;
  localparam logic [7:0] ETM_RD_NONE = 8'h00;

  // count clock select codes
  localparam logic [2:0] ETM_SEL_TI_FALL = 3'h0;
  localparam logic [2:0] ETM_SEL_TI_RISE = 3'h1;

  // prescaler tap (power of two) for the internal clock selects
  function automatic logic [ETM_PRE_W-1:0] etm_tap_mask(
    input logic [2:0] sel
  );
    logic [ETM_PRE_W-1:0] m;
    m = '0;
    case (sel)
      3'h2: m = 11'h001;
      3'h3: m = 11'h003;
      3'h4: m = 11'h007;
      3'h5: m = 11'h01f;
      3'h6: m = 11'h07f;
      3'h7: m = 11'h7ff;
      default: m = 11'h000;
    endcase
    return m;
  endfunction

endpackage

//--- inc/etm_ch_if.sv
// link between the timer top and one counter channel
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface etm_ch_if;
  logic run;
  logic pwm;
  logic [2:0] clk_sel;
  logic ti;
  logic [7:0] cmp;
  logic chain;
  logic ext_tick;
  logic ext_clear;
  logic [7:0] cnt;
  logic tick;
  logic hit;

  modport ctl (
    output run, pwm, clk_sel, ti, cmp, chain, ext_tick, ext_clear,
    input cnt, tick, hit
  );
  modport chan (
    input run, pwm, clk_sel, ti, cmp, chain, ext_tick, ext_clear,
    output cnt, tick, hit
  );
endinterface

//--- rtl/etm_counter.sv
// one 8-bit counter with its own prescaler and input edge detect
// assumes ti is already synchronised to ref_clk_i
`timescale 1ns/1ps
module etm_counter
  import etm_pkg::*;
#(
  parameter bit FOLLOWER = 1'b0
)
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  etm_ch_if.chan ch
);

  logic [ETM_PRE_W-1:0] pre_reg;
  logic [ETM_PRE_W-1:0] pre_next;
  logic ti_prev_reg;
  logic ti_prev_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic own_tick;
  logic [ETM_PRE_W-1:0] mask;

  // count clock pick: pin edges or prescaler tap
  always_comb
  begin
    mask = etm_tap_mask(ch.clk_sel);
    if (ch.clk_sel == ETM_SEL_TI_FALL)
      own_tick = ti_prev_reg & ~ch.ti;
    else if (ch.clk_sel == ETM_SEL_TI_RISE)
      own_tick = ~ti_prev_reg & ch.ti;
    else
      own_tick = ((pre_reg & mask) == mask);
    // follower ignores its own select while chained
    if (FOLLOWER && ch.chain)
      ch.tick = ch.run & ch.ext_tick;
    else
      ch.tick = ch.run & own_tick;
    ch.hit = ch.tick & (cnt_reg == ch.cmp);
    ch.cnt = cnt_reg;
  end

  // next count and prescaler
  always_comb
  begin
    ti_prev_next = ch.ti;
    pre_next = pre_reg + 1'b1;
    cnt_next = cnt_reg;
    if (!ch.run)
    begin
      pre_next = '0;
      cnt_next = ETM_CNT_RST;
    end
    else if (ch.chain && ch.ext_clear)
      cnt_next = ETM_CNT_RST;
    else if (ch.tick)
    begin
      if (!ch.chain && !ch.pwm && (cnt_reg == ch.cmp))
        cnt_next = ETM_CNT_RST;
      else
        cnt_next = cnt_reg + 1'b1;
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      pre_reg <= '0;
      ti_prev_reg <= 1'b0;
      cnt_reg <= ETM_CNT_RST;
    end
    else
    begin
      pre_reg <= pre_next;
      ti_prev_reg <= ti_prev_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule // etm_counter

//--- rtl/etm_top.sv
// three 8-bit timers with compare, mode control and output flip-flops
// assumes an 8-bit register port: data read one cycle after rd_i,
// timer input pins asynchronous, match pulses go to an irq controller
`timescale 1ns/1ps

module etm_top
  import etm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [ETM_ADDR_W-1:0] addr_i,
  input wire logic [ETM_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ETM_DATA_W-1:0] rdata_o,
  input wire logic [ETM_CH_N-1:0] ti_i,
  output logic [ETM_CH_N-1:0] match_irq_o,
  output logic [ETM_CH_N-1:0] timer_out_o,
  output logic [ETM_CH_N-1:0] timer_out_oe_n_o
);

  // register file state
  logic [7:0] mode_reg [ETM_CH_N];
  logic [7:0] mode_next [ETM_CH_N];
  logic [7:0] cmp_reg [ETM_CH_N];
  logic [7:0] cmp_next [ETM_CH_N];
  logic [2:0] csel_reg [ETM_CH_N];
  logic [2:0] csel_next [ETM_CH_N];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // pin synchronisers
  logic [ETM_CH_N-1:0] ti_meta_reg;
  logic [ETM_CH_N-1:0] ti_sync_reg;

  // output side state
  logic [ETM_CH_N-1:0] out_ff_reg;
  logic [ETM_CH_N-1:0] out_ff_next;
  logic [ETM_CH_N-1:0] irq_reg;
  logic [ETM_CH_N-1:0] irq_next;
  logic [ETM_CH_N-1:0] pin_reg;
  logic [ETM_CH_N-1:0] pin_next;
  logic [ETM_CH_N-1:0] oe_n_reg;
  logic [ETM_CH_N-1:0] oe_n_next;

  // decode helpers
  logic [ETM_CH_N-1:0] wr_mode;
  logic [ETM_CH_N-1:0] wr_cmp;
  logic [ETM_CH_N-1:0] wr_csel;
  logic cascade;
  logic [ETM_CH_N-1:0] pwm_eff;
  logic [ETM_CH_N-1:0] run_eff;
  logic [ETM_CH_N-1:0] event_hit;
  logic clear16;

  // channel taps as plain arrays, so loop indices never pick an interface
  logic [7:0] cnt_w [ETM_CH_N];
  logic hit_w [ETM_CH_N];

  etm_ch_if ch_if [ETM_CH_N] ();

  // channel counters; channel 1 may follow channel 0
  for (genvar g = 0; g < ETM_CH_N; g++)
  begin : g_ch
    etm_counter #(
      .FOLLOWER(g == 1)
    ) u_cnt (
      .ref_clk_i(ref_clk_i),
      .srst_i(srst_i),
      .ch(ch_if[g])
    );
  end

  // write address decode
  always_comb
  begin
    wr_mode = '0;
    wr_cmp = '0;
    wr_csel = '0;
    if (wr_i)
    begin
      if (addr_i == ETM_MODE0_OFS)
        wr_mode[0] = 1'b1;
      else if (addr_i == ETM_MODE1_OFS)
        wr_mode[1] = 1'b1;
      else if (addr_i == ETM_MODE2_OFS)
        wr_mode[2] = 1'b1;
      else if (addr_i == ETM_CMP0_OFS)
        wr_cmp[0] = 1'b1;
      else if (addr_i == ETM_CMP1_OFS)
        wr_cmp[1] = 1'b1;
      else if (addr_i == ETM_CMP2_OFS)
        wr_cmp[2] = 1'b1;
      else if (addr_i == ETM_CSEL0_OFS)
        wr_csel[0] = 1'b1;
      else if (addr_i == ETM_CSEL1_OFS)
        wr_csel[1] = 1'b1;
      else if (addr_i == ETM_CSEL2_OFS)
        wr_csel[2] = 1'b1;
    end
  end

  // register file next values
  always_comb
  begin
    for (int i = 0; i < ETM_CH_N; i++)
    begin
      mode_next[i] = mode_reg[i];
      cmp_next[i] = cmp_reg[i];
      csel_next[i] = csel_reg[i];
      // command bits are not stored by a write, so they read zero after it; reset sets bit 2
      if (wr_mode[i])
        mode_next[i] = wdata_i & ETM_MODE_WMASK;
      // any byte, accepted at any time
      if (wr_cmp[i])
        cmp_next[i] = wdata_i;
      if (wr_csel[i])
        csel_next[i] = wdata_i[2:0];
    end
  end

  // read mux, answered in the next cycle
  always_comb
  begin
    rdata_next = ETM_RD_NONE;
    if (rd_i)
    begin
      if (addr_i == ETM_MODE0_OFS)
        rdata_next = mode_reg[0];
      else if (addr_i == ETM_MODE1_OFS)
        rdata_next = mode_reg[1];
      else if (addr_i == ETM_MODE2_OFS)
        rdata_next = mode_reg[2];
      else if (addr_i == ETM_CMP0_OFS)
        rdata_next = cmp_reg[0];
      else if (addr_i == ETM_CMP1_OFS)
        rdata_next = cmp_reg[1];
      else if (addr_i == ETM_CMP2_OFS)
        rdata_next = cmp_reg[2];
      else if (addr_i == ETM_CSEL0_OFS)
        rdata_next = {5'h00, csel_reg[0]};
      else if (addr_i == ETM_CSEL1_OFS)
        rdata_next = {5'h00, csel_reg[1]};
      else if (addr_i == ETM_CSEL2_OFS)
        rdata_next = {5'h00, csel_reg[2]};
      else if (addr_i == ETM_CNT0_OFS)
        rdata_next = ch_if[0].cnt;
      else if (addr_i == ETM_CNT1_OFS)
        rdata_next = ch_if[1].cnt;
      else if (addr_i == ETM_CNT2_OFS)
        rdata_next = ch_if[2].cnt;
    end
  end

  // cascade control: only timer 1's bit counts
  always_comb
  begin
    cascade = mode_reg[1][ETM_CHAIN_BIT];
    for (int i = 0; i < ETM_CH_N; i++)
    begin
      pwm_eff[i] = mode_reg[i][ETM_PWM_BIT];
      run_eff[i] = mode_reg[i][ETM_RUN_BIT];
    end
    // pair runs as one 16-bit clear-and-start timer
    if (cascade)
    begin
      pwm_eff[0] = 1'b0;
      pwm_eff[1] = 1'b0;
      run_eff[1] = run_eff[0];
    end
    // 16-bit compare on timer 0's count clock
    clear16 = cascade & ch_if[0].tick &
      ({ch_if[1].cnt, ch_if[0].cnt} == {cmp_reg[1], cmp_reg[0]});
  end

  // channel drive
  for (genvar g = 0; g < ETM_CH_N; g++)
  begin : g_drv
    assign ch_if[g].run = run_eff[g];
    assign ch_if[g].pwm = pwm_eff[g];
    assign ch_if[g].clk_sel = csel_reg[g];
    assign ch_if[g].ti = ti_sync_reg[g];
    assign ch_if[g].cmp = cmp_reg[g];
    assign ch_if[g].chain = (g < 2) ? cascade : 1'b0;
    assign ch_if[g].ext_clear = clear16;
    // taps read back by the loop-based event logic
    assign cnt_w[g] = ch_if[g].cnt;
    assign hit_w[g] = ch_if[g].hit;
  end

  // carry from timer 0 steps timer 1 while cascaded
  assign ch_if[0].ext_tick = 1'b0;
  assign ch_if[2].ext_tick = 1'b0;
  assign ch_if[1].ext_tick = ch_if[0].tick &
    (ch_if[0].cnt == ETM_CNT_TOP) & ~clear16;

  // match events, flip-flop commands and pin values
  always_comb
  begin
    for (int i = 0; i < ETM_CH_N; i++)
    begin
      // no match interrupt in PWM mode
      event_hit[i] = hit_w[i] & ~pwm_eff[i];
      if (cascade && i < 2)
        event_hit[i] = clear16;
      irq_next[i] = event_hit[i];
      out_ff_next[i] = out_ff_reg[i];
      if (wr_mode[i] && wdata_i[ETM_SET_BIT:ETM_CLR_BIT] == 2'b01)
        out_ff_next[i] = 1'b0;
      else if (wr_mode[i] && wdata_i[ETM_SET_BIT:ETM_CLR_BIT] == 2'b10)
        out_ff_next[i] = 1'b1;
      else if (!pwm_eff[i] && mode_reg[i][ETM_TGL_BIT] && event_hit[i])
        out_ff_next[i] = ~out_ff_reg[i];
      // PWM: active below compare, inactive while stopped
      if (pwm_eff[i])
      begin
        if (run_eff[i])
          pin_next[i] = (cnt_w[i] < cmp_reg[i]) ^
            mode_reg[i][ETM_TGL_BIT];
        else
          pin_next[i] = mode_reg[i][ETM_TGL_BIT];
      end
      else
        pin_next[i] = out_ff_reg[i];
      // drive the pin only when enabled
      oe_n_next[i] = ~mode_reg[i][ETM_DRV_BIT];
    end
  end

  // register file and output registers
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      for (int i = 0; i < ETM_CH_N; i++)
      begin
        mode_reg[i] <= ETM_MODE_RST;
        cmp_reg[i] <= ETM_CMP_RST;
        csel_reg[i] <= ETM_CSEL_RST;
      end
      rdata_reg <= ETM_RD_NONE;
      out_ff_reg <= '0;
      irq_reg <= '0;
      pin_reg <= '0;
      oe_n_reg <= '1;
    end
    else
    begin
      for (int i = 0; i < ETM_CH_N; i++)
      begin
        mode_reg[i] <= mode_next[i];
        cmp_reg[i] <= cmp_next[i];
        csel_reg[i] <= csel_next[i];
      end
      rdata_reg <= rdata_next;
      out_ff_reg <= out_ff_next;
      irq_reg <= irq_next;
      pin_reg <= pin_next;
      oe_n_reg <= oe_n_next;
    end
  end

  // two-stage synchroniser for the timer input pins
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      ti_meta_reg <= '0;
      ti_sync_reg <= '0;
    end
    else
    begin
      ti_meta_reg <= ti_i;
      ti_sync_reg <= ti_meta_reg;
    end
  end

  assign rdata_o = rdata_reg;
  assign match_irq_o = irq_reg;
  assign timer_out_o = pin_reg;
  assign timer_out_oe_n_o = oe_n_reg;

endmodule // etm_top

//--- verif/etm_top_sva.sv
// concurrent checks on the timer block, seen from its top ports
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module etm_top_sva
  import etm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [ETM_ADDR_W-1:0] addr_i,
  input wire logic [ETM_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ETM_DATA_W-1:0] rdata_o,
  input wire logic [ETM_CH_N-1:0] ti_i,
  input wire logic [ETM_CH_N-1:0] match_irq_o,
  input wire logic [ETM_CH_N-1:0] timer_out_o,
  input wire logic [ETM_CH_N-1:0] timer_out_oe_n_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  logic [7:0] sh_reg [ETM_CH_N];

  // shadow of the stored mode bits, written like the real registers
  always_ff @(posedge ref_clk_i)
  begin
    for (int i = 0; i < ETM_CH_N; i++)
      if (srst_i)
        sh_reg[i] <= ETM_MODE_RST;
      else if (wr_i && addr_i == ETM_MODE0_OFS + 16'(2 * i))
        sh_reg[i] <= wdata_i & ETM_MODE_WMASK;
  end

  a_reset_vals: assert property ($past(srst_i) |->
    match_irq_o == '0 && timer_out_o == '0 && timer_out_oe_n_o == '1)
    else $error("outputs not at reset level");
  a_mode_read: assert property ($past(rd_i) &&
    $past(addr_i) == ETM_MODE0_OFS |-> rdata_o == sh_reg[0])
    else $error("mode readback wrong");
  a_set_cmd: assert property (wr_i && addr_i == ETM_MODE0_OFS &&
    wdata_i[7:6] == 2'h0 && wdata_i[3:2] == 2'h2 |-> ##2 timer_out_o[0])
    else $error("set command did not raise output");
  a_clr_cmd: assert property (wr_i && addr_i == ETM_MODE1_OFS &&
    wdata_i[7:6] == 2'h0 && wdata_i[3:2] == 2'h1 |-> ##2 !timer_out_o[1])
    else $error("clear command did not drop output");
  a_pin_driven: assert property (sh_reg[0][0] [*3] |->
    !timer_out_oe_n_o[0])
    else $error("pin not driven");
  a_pin_released: assert property (!sh_reg[0][0] [*3] |->
    timer_out_oe_n_o[0])
    else $error("pin driven while released");
  a_pwm_no_irq: assert property (sh_reg[2][6] [*3] |->
    !match_irq_o[2])
    else $error("match irq in pwm mode");
  a_stop_no_irq: assert property (!sh_reg[0][7] [*3] |->
    !match_irq_o[0])
    else $error("match irq while stopped");
  a_pwm_idle: assert property ((sh_reg[2][7:6] == 2'h1) [*3] |->
    timer_out_o[2] == sh_reg[2][1])
    else $error("stopped pwm output not inactive");
  a_chain_irq: assert property (sh_reg[1][4] [*3] |->
    match_irq_o[0] == match_irq_o[1])
    else $error("cascade irqs not paired");
  a_irq_pulse: assert property (match_irq_o[0] |=>
    !match_irq_o[0])
    else $error("irq longer than one cycle");

  c_irq0: cover property (match_irq_o[0]);
  c_pair: cover property (match_irq_o[0] && match_irq_o[1]);
  c_event: cover property (match_irq_o[1] && !match_irq_o[0]);
  c_pwm_on: cover property (sh_reg[2][6] && timer_out_o[2]);
endmodule // etm_top_sva

bind etm_top etm_top_sva i_sva (.ref_clk_i, .srst_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .ti_i, .match_irq_o, .timer_out_o,
  .timer_out_oe_n_o);

//--- verif/etm_pin_model.sv
// model of the shared timer pins: external events or timer drive
// assumes an undriven pin is pulled down
`timescale 1ns/1ps
module etm_pin_model
  import etm_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [ETM_CH_N-1:0] timer_out_i,
  input wire logic [ETM_CH_N-1:0] timer_out_oe_n_i,
  output logic [ETM_CH_N-1:0] pin_o
);
  logic [ETM_CH_N-1:0] ext_reg = '0;

  // the timer wins the pin while its enable is low
  always_comb
  begin
    for (int i = 0; i < ETM_CH_N; i++)
      pin_o[i] = timer_out_oe_n_i[i] ? ext_reg[i] : timer_out_i[i];
  end

  // n event pulses, each level held for hold clocks
  task automatic pulse(input int ch, input int n, input int hold);
    repeat (n)
    begin
      repeat (hold) @(posedge ref_clk_i);
      ext_reg[ch] <= 1'b1;
      repeat (hold) @(posedge ref_clk_i);
      ext_reg[ch] <= 1'b0;
    end
  endtask
endmodule // etm_pin_model

//--- verif/tb.sv
// self-checking bench for the three-channel timer block
// assumes the pin model on ti_i and a 50 MHz clock
`timescale 1ns/1ps
module tb;
  import etm_pkg::*;
  logic ref_clk_i, srst_i, wr_i, rd_i;
  logic [ETM_ADDR_W-1:0] addr_i;
  logic [ETM_DATA_W-1:0] wdata_i, rdata_o;
  logic [ETM_CH_N-1:0] ti_i, irq, tout, oe_n;
  int n_errors = 0;
  int comparisons = 0;

  etm_top i_dut (.ref_clk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .ti_i, .match_irq_o(irq), .timer_out_o(tout),
    .timer_out_oe_n_o(oe_n));
  etm_pin_model i_pin (.ref_clk_i, .timer_out_i(tout),
    .timer_out_oe_n_i(oe_n), .pin_o(ti_i));

  // 20 ns clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 chk(16'(rdata_o), 16'(e));
  endtask

  // clocks until the next match pulse of channel ch, bounded
  task automatic gap(input int ch, output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk_i);
      n++;
    end
    while (irq[ch] !== 1'b1 && n < 2000);
  endtask

  task automatic t_regs();
    for (int i = 0; i < 3; i++)
      rd(ETM_MODE0_OFS + 16'(2 * i), 8'h04);
    rd(16'hff70, 8'h00);
    wr(ETM_MODE1_OFS, 8'hff);
    rd(ETM_MODE1_OFS, 8'hd3);
    wr(ETM_MODE1_OFS, 8'h04);
    rd(ETM_MODE1_OFS, 8'h00);
    $display("done regs");
  endtask

  task automatic t_outff();
    wr(ETM_MODE0_OFS, 8'h09);
    repeat (2) @(negedge ref_clk_i);
    chk(16'({tout[0], oe_n[0]}), 16'h0002);
    rd(ETM_MODE0_OFS, 8'h01);
    wr(ETM_MODE0_OFS, 8'h04);
    repeat (2) @(negedge ref_clk_i);
    chk(16'({tout[0], oe_n[0]}), 16'h0001);
    $display("done output flip-flop");
  endtask

  task automatic t_interval();
    int n;
    logic t;
    wr(ETM_CSEL0_OFS, 8'h02);
    wr(ETM_CMP0_OFS, 8'h02);
    wr(ETM_MODE0_OFS, 8'h82);
    gap(0, n);
    gap(0, n);
    chk(16'(n), 16'h0006);
    wr(ETM_CMP0_OFS, 8'h04);
    gap(0, n);
    gap(0, n);
    chk(16'(n), 16'h000a);
    t = tout[0];
    @(negedge ref_clk_i);
    chk(16'(tout[0] ^ t), 16'h0001);
    wr(ETM_MODE0_OFS, 8'h00);
    rd(ETM_CNT0_OFS, 8'h00);
    $display("done interval");
  endtask

  task automatic t_event();
    int n;
    wr(ETM_CSEL1_OFS, 8'h01);
    wr(ETM_CMP1_OFS, 8'h03);
    wr(ETM_MODE1_OFS, 8'h80);
    i_pin.pulse(1, 3, 3);
    repeat (6) @(negedge ref_clk_i);
    rd(ETM_CNT1_OFS, 8'h03);
    fork
      i_pin.pulse(1, 1, 3);
      gap(1, n);
    join
    chk(16'(n < 20), 16'h0001);
    rd(ETM_CNT1_OFS, 8'h00);
    wr(ETM_MODE1_OFS, 8'h00);
    $display("done events");
  endtask

  // high cycles and irq cycles of channel 2 over one pwm period
  task automatic duty(output int h, output int e);
    h = 0;
    e = 0;
    repeat (600) @(negedge ref_clk_i);
    repeat (512)
    begin
      @(negedge ref_clk_i);
      h += int'(tout[2]);
      e += int'(irq[2]);
    end
  endtask

  task automatic t_pwm();
    int h;
    int e;
    wr(ETM_CSEL2_OFS, 8'h02);
    wr(ETM_CMP2_OFS, 8'h40);
    wr(ETM_MODE2_OFS, 8'hc1);
    duty(h, e);
    chk(16'(h), 16'h0080);
    chk(16'(e), 16'h0000);
    wr(ETM_MODE2_OFS, 8'hc3);
    duty(h, e);
    chk(16'(h), 16'h0180);
    wr(ETM_MODE2_OFS, 8'h43);
    repeat (3) @(negedge ref_clk_i);
    chk(16'(tout[2]), 16'h0001);
    wr(ETM_MODE2_OFS, 8'h00);
    $display("done pwm");
  endtask

  task automatic t_cascade();
    int n;
    wr(ETM_CMP0_OFS, 8'h01);
    wr(ETM_CMP1_OFS, 8'h02);
    wr(ETM_CSEL1_OFS, 8'h07);
    wr(ETM_MODE1_OFS, 8'h10);
    wr(ETM_CSEL0_OFS, 8'h02);
    wr(ETM_MODE0_OFS, 8'h80);
    // irq 1 is watched only to see the pair; software masks it
    gap(0, n);
    chk(16'(irq[1]), 16'h0001);
    gap(0, n);
    chk(16'(n), 16'h0404);
    // mid-period the high byte is 01h although timer 1's run bit is 0
    repeat (600) @(negedge ref_clk_i);
    rd(ETM_CNT1_OFS, 8'h01);
    wr(ETM_MODE0_OFS, 8'h00);
    rd(ETM_CNT1_OFS, 8'h00);
    rd(ETM_CNT0_OFS, 8'h00);
    wr(ETM_MODE1_OFS, 8'h00);
    $display("done cascade");
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog, about three times the expected run
  initial
  begin
    #300000;
    n_errors++;
    finish_test();
  end

  // main sequence
  initial
  begin
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_outff();
    t_interval();
    t_event();
    t_pwm();
    t_cascade();
    finish_test();
  end
endmodule // tb
